// ==== design/csfm_pkg.sv ====
// Purpose: Shared constants and types for the clock and supply fault monitor
// Assumes: 50 MHz system clock, 32-bit classic Wishbone register bus
// Notes: Word offsets are byte addresses of aligned 32-bit registers
package csfm_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_WDOG_CTL = 8'h00;
  localparam logic [7:0] ADDR_CMP_CTL = 8'h04;
  localparam logic [7:0] ADDR_CMP_REF = 8'h08;
  localparam logic [7:0] ADDR_CMP_TOL = 8'h0C;
  localparam logic [7:0] ADDR_SUP_CTL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_CMP_CNT = 8'h18;
  // Watchdog control field positions
  localparam int WD_FAULTPIN_DIS = 0;
  localparam int WD_LOCK = 1;
  localparam int WD_LOWER_LSB = 2;
  localparam int WD_HARM_EN = 10;
  localparam int WD_CNG_EN = 11;
  localparam int WD_BAD_LSB = 12;
  localparam int WD_BAD_EN = 20;
  localparam int WD_FAULT_EN = 21;
  localparam int WD_CMPMON_DIS = 22;
  localparam logic [31:0] WD_CTL_RESET = 32'h0030_0000;
  // Comparator control
  localparam int CC_EN = 0;
  localparam int CC_AUTO = 1;
  // Supply control
  localparam int SC_EN = 0;
  localparam int SC_UV_LSB = 1;
  localparam int SC_DLY_LSB = 3;
  localparam int SC_TRIP_CMP = 8;
  localparam int SC_TRIP_WD = 9;
  localparam int SC_FPIN_CMP = 10;
  localparam int SC_FPIN_WD = 11;
  localparam int SC_CNG_CMP = 12;
  localparam int SC_SAFE_LVL = 13;
  localparam logic [31:0] SC_CTL_RESET = 32'h0000_0000;
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int AUX_HZ = 1_000_000;
  localparam int AUX_DIV = CLK_HZ / AUX_HZ;
  localparam int REF_DIV = 16;
  localparam int DLY_MIN_US = 1;
  localparam int DLY_MAX_US = 17;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int PPM_SCALE = 1_000_000;
  // Status bit positions
  localparam int ST_WD_HIGH = 0;
  localparam int ST_WD_LOW = 1;
  localparam int ST_WD_HARM = 2;
  localparam int ST_CMP_FAULT = 3;
  localparam int ST_CMP_DEAD = 4;
  localparam int ST_SUP_FAULT = 5;
  localparam int ST_CMP_BUSY = 6;
  localparam int ST_SUP_IRQ = 7;
  // Synchronised supply comparator events
  typedef struct packed {
    logic int_over;
    logic int_under;
    logic ext_over;
    logic ext_under;
  } csfm_supply_t;
  typedef enum logic [1:0] {CMP_IDLE, CMP_RUN, CMP_DONE} csfm_cmp_state_t;
endpackage : csfm_pkg

// ==== design/csfm_top.sv ====
// Purpose: Clock watchdog, clock comparator and supply monitor with a Wishbone slave
// Assumes: Clocks under test and supply events are asynchronous pins
// Notes: Clocks are sampled, so they must stay below a quarter of clk_i
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Watchdog flags input clock too fast, too slow, or oscillating on a harmonic.
// - Watchdog counts input clock edges per 1 MHz auxiliary reference window.
// - One watchdog control register holds pin, lock, limits, enables and monitor-disable.
// - Comparator watches the system clock and raises fault and interrupt on errors.
// - Comparator measures against low-frequency oscillator and faults on excess drift.
// - Gross errors on either clock go to the event controller; dead clock faults.
// - Manual mode runs one detection cycle then stops, fault or not.
// - Automatic mode repeats detection cycles until software stops it, even after faults.
// - Any comparator detection raises an interrupt and asserts a fault.
// - Supply monitor reports over and under voltage events; under-voltage select field is stored but unused.
// - Flash power-down follows power events even when the monitor is disabled.
// - Supply fault delay output programmable from 1 to 17 microseconds.
// - A supply fault starts flash shutdown at once.
// - Each valid supply fault raises the supply-monitor interrupt.
// - A triggered supply monitor drives every pin to the one safe level.
// - Pin safe-state logic can also respond to comparator and watchdog faults.
// - Clock-not-good reset can also respond to comparator faults.
// - System fault pin from watchdog and comparator also controllable by supply control.
module csfm_top #(
  parameter int PIN_W = 16,
  parameter int CNT_W = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Monitored clocks and supply comparators
  input wire logic ext_clk_i,
  input wire logic pll_clk_i,
  input wire logic lfo_clk_i,
  input wire logic [3:0] supply_i,
  // Safety outputs
  output logic sys_fault_n_o,
  output logic clk_not_good_o,
  output logic flash_pdn_o,
  output logic fault_delay_o,
  output logic sup_irq_o,
  output logic cmp_irq_o,
  output logic [1:0] sec_event_o,
  output logic [PIN_W-1:0] pin_o,
  output logic [PIN_W-1:0] pin_oe_o,
  // General-purpose pin values in normal operation
  input wire logic [PIN_W-1:0] gpio_val_i,
  input wire logic [PIN_W-1:0] gpio_oe_i
);
  // Elaboration check: counters and register slices assume these ranges
  if (PIN_W < 1 || PIN_W > 32 || CNT_W < 8 || CNT_W > 32) begin : g_bad_param
    $error("csfm_top: unsupported parameter");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three stages, change accepted when stages two and three agree
  logic [6:0] s1, s2, s3, filt;
  wire logic [6:0] raw = {supply_i, lfo_clk_i, pll_clk_i, ext_clk_i};
  always_ff @(posedge clk_i) begin
    s1 <= raw;
    s2 <= s1;
    s3 <= s2;
  end
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_filt
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          filt[gi] <= 1'b0;
        end else if (s2[gi] == s3[gi]) begin
          filt[gi] <= s3[gi];
        end
      end
    end
  endgenerate
  logic [2:0] filt_d;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_d <= 3'h0;
    end else begin
      filt_d <= filt[2:0];
    end
  end
  wire logic ext_rise = filt[0] & ~filt_d[0];
  wire logic pll_rise = filt[1] & ~filt_d[1];
  wire logic lfo_rise = filt[2] & ~filt_d[2];
  csfm_pkg::csfm_supply_t sup;
  assign sup = csfm_pkg::csfm_supply_t'(filt[6:3]);

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] wd_ctl, cc_ctl, cc_ref, cc_tol, sc_ctl;
  logic [7:0] status;
  logic [CNT_W-1:0] cc_last;
  wire logic bus_req = cyc_i & stb_i & ~ack_o;
  wire logic bus_wr = bus_req & we_i;
  wire logic wr_wd = bus_wr & (adr_i == csfm_pkg::ADDR_WDOG_CTL) & ~wd_ctl[csfm_pkg::WD_LOCK];
  wire logic wr_cc = bus_wr & (adr_i == csfm_pkg::ADDR_CMP_CTL);
  wire logic wr_ref = bus_wr & (adr_i == csfm_pkg::ADDR_CMP_REF);
  wire logic wr_tol = bus_wr & (adr_i == csfm_pkg::ADDR_CMP_TOL);
  wire logic wr_sc = bus_wr & (adr_i == csfm_pkg::ADDR_SUP_CTL);
  wire logic wr_st = bus_wr & (adr_i == csfm_pkg::ADDR_STATUS);
  wire logic [31:0] bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // Ack one cycle after the request; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      case (adr_i)
        csfm_pkg::ADDR_WDOG_CTL: dat_o <= wd_ctl;
        csfm_pkg::ADDR_CMP_CTL: dat_o <= cc_ctl;
        csfm_pkg::ADDR_CMP_REF: dat_o <= cc_ref;
        csfm_pkg::ADDR_CMP_TOL: dat_o <= cc_tol;
        csfm_pkg::ADDR_SUP_CTL: dat_o <= sc_ctl;
        csfm_pkg::ADDR_STATUS: dat_o <= {24'h00_0000, status};
        csfm_pkg::ADDR_CMP_CNT: dat_o <= 32'(cc_last);
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Lock bit freezes the watchdog control word until reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_ctl <= csfm_pkg::WD_CTL_RESET;
      cc_ref <= 32'h0000_0000;
      cc_tol <= 32'h0000_0000;
      sc_ctl <= csfm_pkg::SC_CTL_RESET;
    end else begin
      if (wr_wd) wd_ctl <= merge(wd_ctl, dat_i, bmask);
      if (wr_ref) cc_ref <= merge(cc_ref, dat_i, bmask);
      if (wr_tol) cc_tol <= merge(cc_tol, dat_i, bmask);
      if (wr_sc) sc_ctl <= merge(sc_ctl, dat_i, bmask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator watchdog: edges per 1 us auxiliary window
  logic [5:0] aux_cnt;
  logic [7:0] wd_edges, wd_prev;
  wire logic aux_tick = (aux_cnt == 6'(csfm_pkg::AUX_DIV - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_cnt <= 6'h00;
      wd_edges <= 8'h00;
      wd_prev <= 8'h00;
    end else begin
      aux_cnt <= aux_tick ? 6'h00 : aux_cnt + 6'h01;
      if (aux_tick) begin
        wd_edges <= {7'h00, ext_rise};
        wd_prev <= wd_edges;
      end else if (ext_rise && wd_edges != 8'hFF) begin
        wd_edges <= wd_edges + 8'h01;
      end
    end
  end
  wire logic [7:0] wd_low_lim = wd_ctl[csfm_pkg::WD_LOWER_LSB +: 8];
  wire logic [7:0] wd_bad_lim = wd_ctl[csfm_pkg::WD_BAD_LSB +: 8];
  // Harmonic: window count jumps to at least twice the previous one, less one
  wire logic wd_harm_hit = aux_tick & wd_ctl[csfm_pkg::WD_HARM_EN] & (wd_prev != 8'h00)
                         & (wd_edges >= {wd_prev[6:0], 1'b0} - 8'h01);
  wire logic wd_high_hit = aux_tick & wd_ctl[csfm_pkg::WD_BAD_EN] & (wd_edges > wd_bad_lim);
  wire logic wd_low_hit = aux_tick & (wd_edges < wd_low_lim);

  //////////////////////////////////////////////////////////////////////////////
  // Clock comparator: window of cc_ref*16 oscillator edges, count system clock edges
  csfm_pkg::csfm_cmp_state_t cc_state, next_cc_state;
  logic [CNT_W+3:0] lfo_cnt; // Spans the whole ref*16 window
  logic [CNT_W-1:0] pll_cnt, gross_cnt;
  wire logic [CNT_W+3:0] win_len = {cc_ref[CNT_W-1:0], 4'h0};
  wire logic [CNT_W-1:0] exp_cnt = cc_ref[CNT_W-1:0];
  // Tolerance sum in ppm, lower 16 bits system clock, upper 16 bits oscillator
  wire logic [16:0] tol_ppm = {1'b0, cc_tol[15:0]} + {1'b0, cc_tol[31:16]};
  wire logic [CNT_W+16:0] tol_prod = exp_cnt * tol_ppm;
  wire logic [CNT_W-1:0] tol_cnt = CNT_W'(tol_prod / csfm_pkg::PPM_SCALE) + CNT_W'(1);
  wire logic [CNT_W-1:0] lim_hi = exp_cnt + tol_cnt;
  wire logic [CNT_W-1:0] lim_lo = (exp_cnt > tol_cnt) ? exp_cnt - tol_cnt : '0;
  wire logic win_end = (cc_state == csfm_pkg::CMP_RUN) & lfo_rise
                     & (lfo_cnt == win_len - (CNT_W+4)'(1));
  // Expected system edges per oscillator edge at most 16x over count; flag dead oscillator
  wire logic gross_hit = (cc_state == csfm_pkg::CMP_RUN) & (gross_cnt == '1);
  wire logic drift_hit = win_end & ((pll_cnt > lim_hi) | (pll_cnt < lim_lo));
  wire logic dead_hit = win_end & (pll_cnt == '0);
  wire logic cycle_end = win_end | gross_hit;
  wire logic cc_go = wr_cc & dat_i[csfm_pkg::CC_EN] & ~wd_ctl[csfm_pkg::WD_CMPMON_DIS];

  // Manual stops after one cycle; automatic loops until software clears enable
  always_comb begin
    next_cc_state = cc_state;
    case (cc_state)
      csfm_pkg::CMP_IDLE: if (cc_go) next_cc_state = csfm_pkg::CMP_RUN;
      csfm_pkg::CMP_RUN: begin
        if (!cc_ctl[csfm_pkg::CC_EN]) next_cc_state = csfm_pkg::CMP_IDLE;
        else if (cycle_end && !cc_ctl[csfm_pkg::CC_AUTO]) next_cc_state = csfm_pkg::CMP_DONE;
        else next_cc_state = csfm_pkg::CMP_RUN;
      end
      csfm_pkg::CMP_DONE: next_cc_state = csfm_pkg::CMP_IDLE;
      default: next_cc_state = csfm_pkg::CMP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cc_state <= csfm_pkg::CMP_IDLE;
      cc_ctl <= 32'h0000_0000;
      lfo_cnt <= '0;
      pll_cnt <= '0;
      gross_cnt <= '0;
      cc_last <= '0;
    end else begin
      cc_state <= next_cc_state;
      if (wr_cc) cc_ctl <= merge(cc_ctl, dat_i, bmask);
      else if (next_cc_state == csfm_pkg::CMP_DONE) cc_ctl[csfm_pkg::CC_EN] <= 1'b0;
      if (cc_state != csfm_pkg::CMP_RUN || cycle_end) begin
        lfo_cnt <= '0;
        pll_cnt <= '0;
        gross_cnt <= '0;
      end else begin
        if (lfo_rise) lfo_cnt <= lfo_cnt + (CNT_W+4)'(1);
        if (pll_rise) pll_cnt <= pll_cnt + CNT_W'(1);
        gross_cnt <= lfo_rise ? '0 : gross_cnt + CNT_W'(1);
      end
      if (win_end) cc_last <= pll_cnt;
    end
  end
  wire logic cc_fault = drift_hit | dead_hit | gross_hit;

  //////////////////////////////////////////////////////////////////////////////
  // Supply monitor: under-voltage select field is held in sc_ctl but not used
  wire logic sc_en = sc_ctl[csfm_pkg::SC_EN];
  wire logic [1:0] uv_sel = sc_ctl[csfm_pkg::SC_UV_LSB +: 2];
  wire logic power_event = sup.int_over | sup.int_under | sup.ext_over | sup.ext_under;
  wire logic sup_hit = sc_en & power_event;
  wire logic [4:0] dly_us = sc_ctl[csfm_pkg::SC_DLY_LSB +: 5];
  // Clamp requested delay into 1..17 us
  wire logic [4:0] dly_clamp = (dly_us < 5'(csfm_pkg::DLY_MIN_US)) ? 5'(csfm_pkg::DLY_MIN_US) :
                               (dly_us > 5'(csfm_pkg::DLY_MAX_US)) ? 5'(csfm_pkg::DLY_MAX_US) :
                               dly_us;
  wire logic [10:0] dly_cyc = 11'(dly_clamp * csfm_pkg::CYC_PER_US);
  logic [10:0] dly_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status except the live busy bit; hardware set wins over a software write-one-to-clear
  logic [7:0] st_set;
  assign st_set[csfm_pkg::ST_WD_HIGH] = wd_high_hit | wd_harm_hit;
  assign st_set[csfm_pkg::ST_WD_LOW] = wd_low_hit;
  assign st_set[csfm_pkg::ST_WD_HARM] = wd_harm_hit;
  assign st_set[csfm_pkg::ST_CMP_FAULT] = cc_fault;
  assign st_set[csfm_pkg::ST_CMP_DEAD] = dead_hit | gross_hit;
  assign st_set[csfm_pkg::ST_SUP_FAULT] = sup_hit;
  assign st_set[csfm_pkg::ST_CMP_BUSY] = 1'b0;
  assign st_set[csfm_pkg::ST_SUP_IRQ] = sup_hit;
  wire logic [7:0] st_clr = wr_st & sel_i[0] ? dat_i[7:0] : 8'h00;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= 8'h00;
      dly_cnt <= 11'h000;
      fault_delay_o <= 1'b0;
    end else begin
      status <= (status & ~st_clr) | st_set;
      status[csfm_pkg::ST_CMP_BUSY] <= (next_cc_state == csfm_pkg::CMP_RUN);
      if (!status[csfm_pkg::ST_SUP_FAULT]) begin
        dly_cnt <= 11'h000;
        fault_delay_o <= 1'b0;
      end else if (dly_cnt < dly_cyc) begin
        dly_cnt <= dly_cnt + 11'h001;
      end else begin
        fault_delay_o <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault routing
  wire logic wd_fault = |status[2:0];
  wire logic cmp_fault = |status[4:3];
  wire logic wd_fault_pin = wd_fault & wd_ctl[csfm_pkg::WD_FAULT_EN]
                          & ~wd_ctl[csfm_pkg::WD_FAULTPIN_DIS];
  wire logic cng = wd_ctl[csfm_pkg::WD_CNG_EN]
                 & (wd_fault | (cmp_fault & sc_ctl[csfm_pkg::SC_CNG_CMP]));
  wire logic safe_trip = status[csfm_pkg::ST_SUP_FAULT]
                       | (cmp_fault & sc_ctl[csfm_pkg::SC_TRIP_CMP])
                       | (wd_fault & sc_ctl[csfm_pkg::SC_TRIP_WD]);
  wire logic fault_pin = wd_fault_pin | cmp_fault
                       | (wd_fault & sc_ctl[csfm_pkg::SC_FPIN_WD])
                       | (cmp_fault & sc_ctl[csfm_pkg::SC_FPIN_CMP])
                       | status[csfm_pkg::ST_SUP_FAULT];
  // Flash power-down ignores enable so a dying supply still protects flash
  wire logic flash_req = power_event | status[csfm_pkg::ST_SUP_FAULT];
  wire logic [PIN_W-1:0] safe_val = {PIN_W{sc_ctl[csfm_pkg::SC_SAFE_LVL]}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_fault_n_o <= 1'b1;
      clk_not_good_o <= 1'b0;
      flash_pdn_o <= 1'b0;
      sup_irq_o <= 1'b0;
      cmp_irq_o <= 1'b0;
      sec_event_o <= 2'h0;
      pin_o <= '0;
      pin_oe_o <= '0;
    end else begin
      sys_fault_n_o <= ~fault_pin;
      clk_not_good_o <= cng;
      flash_pdn_o <= flash_req;
      sup_irq_o <= status[csfm_pkg::ST_SUP_IRQ];
      cmp_irq_o <= cmp_fault;
      sec_event_o <= {gross_hit, cc_fault};
      pin_o <= safe_trip ? safe_val : gpio_val_i;
      pin_oe_o <= safe_trip ? {PIN_W{1'b1}} : gpio_oe_i;
    end
  end
  wire logic unused = ^{uv_sel, cc_ctl[31:2]};
endmodule : csfm_top

// ==== bench/csfm_top_chk.sv ====
// Purpose: Concurrent checks on the ports of the clock and supply fault monitor
// Assumes: One clock domain, synchronous active-high reset
// Notes: Latency windows allow for the three-stage input synchronisers
module csfm_top_chk #(
  parameter int PIN_W = 16
) (
  // Clock, reset and bus handshake
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Supply and pin side
  input wire logic [3:0] supply_i,
  input wire logic [PIN_W-1:0] gpio_oe_i,
  input wire logic [PIN_W-1:0] pin_o,
  input wire logic [PIN_W-1:0] pin_oe_o,
  // Fault outputs
  input wire logic sys_fault_n_o,
  input wire logic flash_pdn_o,
  input wire logic fault_delay_o,
  input wire logic sup_irq_o,
  input wire logic cmp_irq_o,
  input wire logic [1:0] sec_event_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  // Bus request and its single-cycle answer
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_ans; ack_o ##1 !ack_o; endsequence
  property p_ack_once; s_req |=> s_ans; endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack did not come as one pulse after the request");
  // Outputs leave reset quiet; the fault pin idles high
  property p_rst_vals;
    $fell(rst_i) |-> sys_fault_n_o && !flash_pdn_o && !ack_o && !sup_irq_o && !cmp_irq_o;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("outputs not at reset values after reset");
  // Flash power-down follows any supply event, enabled or not
  property p_flash; $rose(|supply_i) |-> ##[1:6] flash_pdn_o; endproperty
  a_flash: assert property (p_flash)
    else $error("flash power-down late after supply event");
  // Comparator fault event is a single pulse
  property p_sec_pulse; sec_event_o[0] |=> !sec_event_o[0]; endproperty
  a_sec_pulse: assert property (p_sec_pulse)
    else $error("comparator event longer than one cycle");
  property p_cmp_irq; sec_event_o[0] |-> ##[0:2] cmp_irq_o; endproperty
  a_cmp_irq: assert property (p_cmp_irq)
    else $error("comparator fault without interrupt");
  property p_cmp_pin; sec_event_o[0] |-> ##[0:2] !sys_fault_n_o; endproperty
  a_cmp_pin: assert property (p_cmp_pin)
    else $error("comparator fault did not drive the fault pin");
  // Fault delay never rises sooner than 40 cycles after the supply interrupt
  property p_fdly; $rose(fault_delay_o) |-> $past(sup_irq_o, 40); endproperty
  a_fdly: assert property (p_fdly)
    else $error("fault delay rose too soon after supply fault");
  // A tripped pin bank drives every pin at one safe level
  property p_safe;
    (pin_oe_o != gpio_oe_i) |-> pin_oe_o == {PIN_W{1'b1}} && pin_o == {PIN_W{pin_o[0]}};
  endproperty
  a_safe: assert property (p_safe)
    else $error("safe state pins not uniformly driven");
endmodule : csfm_top_chk

bind csfm_top csfm_top_chk #(.PIN_W(PIN_W)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
  .supply_i, .gpio_oe_i, .pin_o, .pin_oe_o, .sys_fault_n_o, .flash_pdn_o, .fault_delay_o,
  .sup_irq_o, .cmp_irq_o, .sec_event_o);

// ==== bench/csfm_far_model.sv ====
// Purpose: Far-side model of the watched clocks and supply comparators
// Assumes: Half periods in ns come from the bench; zero stops a clock
// Notes: Stopped clocks stand low; supply events land off the clk_i grid
module csfm_far_model (
  // Bench controls
  input var int ext_half_i,
  input var int pll_half_i,
  input var int lfo_half_i,
  input wire logic [3:0] sup_req_i,
  // Far-side signals
  output logic ext_clk_o,
  output logic pll_clk_o,
  output logic lfo_clk_o,
  output logic [3:0] supply_o
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////
  // One half period per call; a stopped clock polls its setting
  task automatic step(input int h, ref logic c);
    if (h == 0) begin
      c = 1'b0;
      #7;
    end else begin
      #(h) c = ~c;
    end
  endtask : step
  initial begin
    ext_clk_o = 1'b0;
    pll_clk_o = 1'b0;
    lfo_clk_o = 1'b0;
    supply_o = 4'h0;
  end
  always step(ext_half_i, ext_clk_o);
  always step(pll_half_i, pll_clk_o);
  always step(lfo_half_i, lfo_clk_o);
  // Comparators answer asynchronously, 7 ns off the request
  always @(sup_req_i) supply_o <= #7 sup_req_i;
endmodule : csfm_far_model

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the clock and supply fault monitor
// Assumes: Wishbone master tasks; far-side model makes clocks and supply events
// Notes: Gross-error timeout shortened with CNT_W = 8
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [15:0] gpio_val_i = 16'hFFFF;
  logic [15:0] gpio_oe_i = 16'h0000;
  logic [3:0] sup_req = 4'h0;
  logic [31:0] dat_o, rd;
  logic ack_o, ext_clk_i, pll_clk_i, lfo_clk_i, sys_fault_n_o, clk_not_good_o;
  logic flash_pdn_o, fault_delay_o, sup_irq_o, cmp_irq_o;
  logic [1:0] sec_event_o;
  logic [3:0] supply_i;
  logic [15:0] pin_o, pin_oe_o;
  int ext_half = 0, pll_half = 3200, lfo_half = 200, n, s0, s1;
  int error_cnt = 0, samples_checked = 0, sec0_cnt = 0, sec1_cnt = 0;
  int pll_tab[3] = '{3200, 0, 1600};
  logic flt_tab[3] = '{1'b0, 1'b1, 1'b1};
  int dly_set[4] = '{0, 3, 17, 25};
  int dly_exp[4] = '{1, 3, 17, 17};
`define CHK(nm, e_v, g_v) begin samples_checked++; if ((g_v) !== (e_v)) begin error_cnt++; \
  $display("Error %s expected %0h seen %0h", nm, e_v, g_v); end end
  ////////////////////////////////////////////////////////////
  always #10 clk_i = ~clk_i;
  csfm_top #(.PIN_W(16), .CNT_W(8)) dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .ext_clk_i, .pll_clk_i, .lfo_clk_i, .supply_i, .sys_fault_n_o,
    .clk_not_good_o, .flash_pdn_o, .fault_delay_o, .sup_irq_o, .cmp_irq_o, .sec_event_o,
    .pin_o, .pin_oe_o, .gpio_val_i, .gpio_oe_i);
  csfm_far_model u_far (.ext_half_i(ext_half), .pll_half_i(pll_half), .lfo_half_i(lfo_half),
    .sup_req_i(sup_req), .ext_clk_o(ext_clk_i), .pll_clk_o(pll_clk_i), .lfo_clk_o(lfo_clk_i),
    .supply_o(supply_i));
  // Event pulses last one cycle, so they are counted rather than polled
  always @(posedge clk_i) begin
    if (sec_event_o[0] === 1'b1)
      sec0_cnt <= sec0_cnt + 1;
    if (sec_event_o[1] === 1'b1)
      sec1_cnt <= sec1_cnt + 1;
  end
  task automatic idle(input int c);
    repeat (c) @(posedge clk_i);
  endtask : idle
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (k >= 20) begin
      error_cnt++;
      $display("Error bus ack expected 1 seen timeout");
    end
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string nm);
    wb(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, rd & m)
  endtask : rdc
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int k = 0;
    do begin
      wb(1'b0, a, 32'h0000_0000);
      k++;
    end while (rd[b] !== v && k < 2000);
    `CHK("poll bit", v, rd[b])
  endtask : poll
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////
  // Main sequence; registers first, then each monitor in turn
  initial begin
    idle(2);
    rst_i <= 1'b0;
    rdc(csfm_pkg::ADDR_WDOG_CTL, 32'hFFFF_FFFF, csfm_pkg::WD_CTL_RESET, "wd ctl");
    wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    rdc(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    $display("Done registers");
    // Watchdog: in range, too fast, then dead; trips pins high
    ext_half <= 250;
    gpio_val_i <= 16'h0000;
    wb(1'b1, csfm_pkg::ADDR_SUP_CTL, 32'h0000_2201);
    wb(1'b1, csfm_pkg::ADDR_WDOG_CTL, 32'h0030_3C04);
    idle(200);
    wb(1'b1, csfm_pkg::ADDR_STATUS, 32'h0000_00FF);
    idle(200);
    rdc(csfm_pkg::ADDR_STATUS, 32'h0000_0007, 32'h0000_0000, "wd ok");
    `CHK("pin oe idle", 16'h0000, pin_oe_o);
    ext_half <= 100;
    idle(200);
    rdc(csfm_pkg::ADDR_STATUS, 32'h0000_0005, 32'h0000_0005, "wd high");
    `CHK("wd fault pin", 1'b0, sys_fault_n_o);
    `CHK("wd cng", 1'b1, clk_not_good_o);
    `CHK("wd safe pins", 16'hFFFF, pin_o);
    `CHK("wd safe oe", 16'hFFFF, pin_oe_o);
    ext_half <= 0;
    idle(200);
    rdc(csfm_pkg::ADDR_STATUS, 32'h0000_0002, 32'h0000_0002, "wd low");
    rst_i <= 1'b1;
    gpio_val_i <= 16'hFFFF;
    idle(2);
    rst_i <= 1'b0;
    rdc(csfm_pkg::ADDR_WDOG_CTL, 32'hFFFF_FFFF, csfm_pkg::WD_CTL_RESET, "wd ctl");
    $display("Done watchdog");
    // Manual runs: nominal, dead and double-rate monitored clock
    for (int i = 0; i < 3; i++) begin
      pll_half <= pll_tab[i];
      idle(400);
      wb(1'b1, csfm_pkg::ADDR_CMP_REF, 32'h0000_0004);
      wb(1'b1, csfm_pkg::ADDR_CMP_TOL, 32'h0000_0000);
      wb(1'b1, csfm_pkg::ADDR_STATUS, 32'h0000_00FF);
      wb(1'b1, csfm_pkg::ADDR_CMP_CTL, 32'h0000_0001);
      poll(csfm_pkg::ADDR_CMP_CTL, 0, 1'b0);
      rdc(csfm_pkg::ADDR_STATUS, 32'h48, flt_tab[i] ? 32'h08 : 32'h00, "cmp");
      `CHK("cmp irq", flt_tab[i], cmp_irq_o);
      if (i == 0) begin
        wb(1'b0, csfm_pkg::ADDR_CMP_CNT, 32'h0000_0000);
        `CHK("cmp count", 1'b1, rd >= 3 && rd <= 5);
      end
    end
    `CHK("cmp fault pin", 1'b0, sys_fault_n_o);
    // Automatic mode keeps running through faults
    pll_half <= 0;
    s0 = sec0_cnt;
    wb(1'b1, csfm_pkg::ADDR_CMP_CTL, 32'h0000_0003);
    idle(3500);
    rdc(csfm_pkg::ADDR_CMP_CTL, 32'h3, 32'h3, "auto ctl");
    rdc(csfm_pkg::ADDR_STATUS, 32'h48, 32'h48, "auto busy");
    `CHK("auto repeats", 1'b1, sec0_cnt >= s0 + 2);
    pll_half <= 3200;
    idle(400);
    s1 = sec1_cnt;
    lfo_half <= 0;
    idle(600);
    `CHK("gross event", 1'b1, sec1_cnt > s1);
    wb(1'b1, csfm_pkg::ADDR_CMP_CTL, 32'h0000_0000);
    idle(5);
    rdc(csfm_pkg::ADDR_STATUS, 32'h40, 32'h00, "auto stop");
    lfo_half <= 200;
    $display("Done comparator");
    // Supply: flash follows a disabled monitor, then every event with delay settings 0, 3, 17 and 25
    wb(1'b1, csfm_pkg::ADDR_SUP_CTL, 32'h0000_0000);
    sup_req <= 4'h4;
    idle(10);
    `CHK("flash off", 1'b1, flash_pdn_o);
    `CHK("irq off", 1'b0, sup_irq_o);
    sup_req <= 4'h0;
    idle(10);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, csfm_pkg::ADDR_SUP_CTL, 32'((dly_set[i] << csfm_pkg::SC_DLY_LSB) | 1));
      wb(1'b1, csfm_pkg::ADDR_STATUS, 32'h0000_00FF);
      n = 0;
      sup_req <= 4'h1 << i;
      do begin
        @(posedge clk_i);
        n++;
      end while (fault_delay_o !== 1'b1 && n < 1200);
      `CHK("delay", 1'b1, n >= dly_exp[i] * 50 && n <= dly_exp[i] * 50 + 12);
      `CHK("sup irq", 1'b1, sup_irq_o);
      `CHK("safe pins", 16'h0000, pin_o);
      `CHK("safe oe", 16'hFFFF, pin_oe_o);
      `CHK("flash", 1'b1, flash_pdn_o);
      rdc(csfm_pkg::ADDR_STATUS, 32'h20, 32'h20, "sup fault");
      sup_req <= 4'h0;
      idle(10);
      wb(1'b1, csfm_pkg::ADDR_STATUS, 32'h0000_00FF);
      idle(2);
      `CHK("irq cleared", 1'b0, sup_irq_o);
    end
    $display("Done supply");
    // Locked control register ignores later writes
    wb(1'b1, csfm_pkg::ADDR_WDOG_CTL, 32'h0000_0002);
    wb(1'b1, csfm_pkg::ADDR_WDOG_CTL, 32'h0030_0000);
    rdc(csfm_pkg::ADDR_WDOG_CTL, 32'hFFFF_FFFF, 32'h0000_0002, "locked");
    $display("Done lock");
    tally_and_finish();
  end
  // Whole run needs about 13k cycles; 1 ms is ample headroom
  initial begin
    #1_000_000;
    error_cnt++;
    $display("Error run expected finish seen timeout");
    tally_and_finish();
  end
endmodule : tb_top
